//--- logic/dual_irq_generator.sv
// device end: two independent interrupt generators on the request lines
// Notes on behaviour
// - two independent generators, any of seven lines
// - request only on an enabled status event
// - generator index is only 0 or 1
// - priority 1..7 selects the request line
// - priority 0 disables, 7 is highest
// - only status bits 8..13 are sources
// - mask bit n enables status bit n+8
// - status bits 14 and 15 never interrupt
// - acknowledge clears the acknowledged generator's mask
// - cleared mask stays quiet until rewrite or restore
// - saved copy of last programmed mask
// - restore reloads working masks from saved copies
// - mask and priority read back separately
`timescale 1ns/100ps
module dual_irq_generator (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// status word from the digitizer
	input wire logic [15:0] i_status,
	// link to the handler
	irq_gen_if.device link,
	// per-generator pending view
	output logic [1:0] o_pending
);
	logic [7:0] mask_r [2];
	logic [7:0] mask_nxt [2];
	logic [7:0] saved_r [2];
	logic [7:0] saved_nxt [2];
	logic [2:0] prio_r [2];
	logic [2:0] prio_nxt [2];
	logic [1:0] pend_r;
	logic [1:0] pend_nxt;
	logic [15:0] status_prev_r;
	logic [7:0] readback_r;
	logic [7:0] readback_nxt;
	logic rb_valid_r;
	logic rb_valid_nxt;
	logic ack_done_r;
	logic ack_done_nxt;
	logic ack_gen_r;
	logic ack_gen_nxt;
	logic [7:0] rise;
	logic [7:0] lines;
	logic [15:0] status_prev_nxt;
	logic [1:0] ack_sel;

	// level 0 is the off setting and never drives a line
	function automatic logic is_live(input logic [2:0] p);
		return p != irq_gen_pkg::PRIO_OFF;
	endfunction

	// one-hot active-high line image for a priority level; level 0 drives nothing
	function automatic logic [7:0] line_of(input logic [2:0] p);
		logic [7:0] v;
		v = 8'h00;
		if (is_live(p))
			v[p] = 1'b1;
		return v;
	endfunction

	// rising edges of the eligible upper byte only; 14 and 15 masked off
	assign rise = (i_status[15:8] & ~status_prev_r[15:8]) & irq_gen_pkg::MASK_USABLE;

	always_comb
	begin
		lines = 8'h00;
		for (int g = 0; g < irq_gen_pkg::GEN_COUNT; g++)
		begin
			if (pend_r[g])
				lines = lines | line_of(prio_r[g]);
		end
	end
	// bit 0 unused: level 0 is off
	assign link.irq_n = ~lines;
	assign link.readback = readback_r;
	assign link.readback_valid = rb_valid_r;
	assign link.ack_done = ack_done_r;
	assign link.ack_generator = ack_gen_r;
	assign o_pending = pend_r;

	// acknowledge: lowest index at that level answers first
	always_comb
	begin
		logic hit;
		hit = 1'b0;
		ack_sel = 2'b00;
		if (link.ack_strobe)
		begin
			for (int g = 0; g < irq_gen_pkg::GEN_COUNT; g++)
			begin
				if (!hit && pend_r[g] && prio_r[g] == link.ack_level && is_live(prio_r[g]))
				begin
					hit = 1'b1;
					ack_sel[g] = 1'b1;
				end
			end
		end
		ack_done_nxt = hit;
		ack_gen_nxt = ack_gen_r;
		if (hit)
			ack_gen_nxt = ack_sel[1];
	end

	// configuration: working mask, saved mask and level per generator
	always_comb
	begin
		for (int g = 0; g < irq_gen_pkg::GEN_COUNT; g++)
		begin
			mask_nxt[g] = mask_r[g];
			saved_nxt[g] = saved_r[g];
			prio_nxt[g] = prio_r[g];
			if (ack_sel[g])
				mask_nxt[g] = irq_gen_pkg::MASK_RESET;
		end
		if (link.configure_op)
		begin
			mask_nxt[link.generator_index] = link.cfg_mask;
			saved_nxt[link.generator_index] = link.cfg_mask;
			prio_nxt[link.generator_index] = link.cfg_priority;
		end
		else if (link.restore_op)
		begin
			for (int g = 0; g < irq_gen_pkg::GEN_COUNT; g++)
				mask_nxt[g] = saved_r[g];
		end
	end

	always_comb
	begin
		for (int g = 0; g < irq_gen_pkg::GEN_COUNT; g++)
		begin
			pend_nxt[g] = pend_r[g] && !ack_sel[g];
			// a new event is not lost in the acknowledge cycle
			if (|(rise & mask_r[g]) && is_live(prio_r[g]))
				pend_nxt[g] = 1'b1;
			// reprogramming to level 0 forgets a waiting request
			if (!is_live(prio_nxt[g]))
				pend_nxt[g] = 1'b0;
		end
	end

	// configure and restore outrank the readbacks in one cycle
	always_comb
	begin
		readback_nxt = readback_r;
		rb_valid_nxt = 1'b0;
		if (!link.configure_op && !link.restore_op)
		begin
			if (link.mask_readback_op)
			begin
				readback_nxt = mask_r[link.generator_index];
				rb_valid_nxt = 1'b1;
			end
			else if (link.priority_readback_op)
			begin
				readback_nxt = {5'h00, prio_r[link.generator_index]};
				rb_valid_nxt = 1'b1;
			end
		end
	end

	always_comb
	begin
		status_prev_nxt = i_status;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			status_prev_r <= 16'h0000;
		else
			status_prev_r <= status_prev_nxt;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			for (int g = 0; g < irq_gen_pkg::GEN_COUNT; g++)
			begin
				mask_r[g] <= irq_gen_pkg::MASK_RESET;
				saved_r[g] <= irq_gen_pkg::MASK_RESET;
				prio_r[g] <= irq_gen_pkg::PRIO_RESET;
			end
		end
		else
		begin
			for (int g = 0; g < irq_gen_pkg::GEN_COUNT; g++)
			begin
				mask_r[g] <= mask_nxt[g];
				saved_r[g] <= saved_nxt[g];
				prio_r[g] <= prio_nxt[g];
			end
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			pend_r <= 2'h0;
		else
			pend_r <= pend_nxt;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			ack_done_r <= 1'b0;
			ack_gen_r <= 1'b0;
		end
		else
		begin
			ack_done_r <= ack_done_nxt;
			ack_gen_r <= ack_gen_nxt;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			readback_r <= 8'h00;
			rb_valid_r <= 1'b0;
		end
		else
		begin
			readback_r <= readback_nxt;
			rb_valid_r <= rb_valid_nxt;
		end
	end
endmodule

//--- logic/irq_gen_if.sv
// link between the digitizer interrupt generators and the bus handler
`timescale 1ns/100ps
interface irq_gen_if;
	logic [7:0] irq_n;
	logic configure_op;
	logic restore_op;
	logic mask_readback_op;
	logic priority_readback_op;
	logic generator_index;
	logic [7:0] cfg_mask;
	logic [2:0] cfg_priority;
	logic [7:0] readback;
	logic readback_valid;
	logic ack_strobe;
	logic [2:0] ack_level;
	logic ack_done;
	logic ack_generator;
	modport device (
		output irq_n, readback, readback_valid, ack_done, ack_generator,
		input configure_op, restore_op, mask_readback_op, priority_readback_op,
		input generator_index, cfg_mask, cfg_priority, ack_strobe, ack_level
	);
	modport host (
		input irq_n, readback, readback_valid, ack_done, ack_generator,
		output configure_op, restore_op, mask_readback_op, priority_readback_op,
		output generator_index, cfg_mask, cfg_priority, ack_strobe, ack_level
	);
endinterface

//--- logic/irq_gen_pkg.sv
// shared constants for the dual interrupt generator and its handler
package irq_gen_pkg;
	localparam int GEN_COUNT = 2;
	localparam int STATUS_W = 16;
	localparam int MASK_W = 8;
	localparam int PRIO_W = 3;
	localparam int SRC_LSB = 8;
	localparam logic [7:0] MASK_USABLE = 8'h3F;
	localparam logic [2:0] PRIO_OFF = 3'h0;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [2:0] PRIO_RESET = 3'h0;
	// handler register offsets
	localparam logic [3:0] ADDR_CMD = 4'h0;
	localparam logic [3:0] ADDR_CFG = 4'h1;
	localparam logic [3:0] ADDR_RESULT = 4'h2;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
	localparam logic [3:0] ADDR_VECTOR = 4'h5;
	// command codes written to ADDR_CMD bits 2:0
	localparam logic [2:0] CMD_CONFIGURE = 3'h1;
	localparam logic [2:0] CMD_RESTORE = 3'h2;
	localparam logic [2:0] CMD_MASK_READ = 3'h3;
	localparam logic [2:0] CMD_PRIO_READ = 3'h4;
	localparam logic [2:0] CMD_ACK = 3'h5;
	// handler interrupt status bits
	localparam int EV_REQ = 0;
	localparam int EV_DONE = 1;
	localparam int EV_BAD_INDEX = 2;
endpackage

//--- logic/irq_handler.sv
// host end: bus interrupt handler with a software register port
`timescale 1ns/100ps
module irq_handler (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// software register port
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// interrupt to software
	output logic o_irq,
	// link to the device
	irq_gen_if.host link
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} state_e;
	state_e state_r;
	state_e state_nxt;
	logic [2:0] op_r;
	logic [2:0] op_nxt;
	logic idx_r;
	logic idx_nxt;
	logic [7:0] mask_r;
	logic [7:0] mask_nxt;
	logic [2:0] prio_r;
	logic [2:0] prio_nxt;
	logic [2:0] lvl_r;
	logic [2:0] lvl_nxt;
	logic [7:0] result_r;
	logic [7:0] result_nxt;
	logic [4:0] vector_r;
	logic [4:0] vector_nxt;
	logic [2:0] ists_r;
	logic [2:0] ists_nxt;
	logic [2:0] imsk_r;
	logic [2:0] imsk_nxt;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic [2:0] top_level;

	// highest active request line
	always_comb
	begin
		top_level = 3'h0;
		for (int l = 1; l < 8; l++)
		begin
			if (!link.irq_n[l])
				top_level = 3'(l);
		end
	end

	assign link.configure_op = state_r == ST_WAIT && op_r == irq_gen_pkg::CMD_CONFIGURE;
	assign link.restore_op = state_r == ST_WAIT && op_r == irq_gen_pkg::CMD_RESTORE;
	assign link.mask_readback_op = state_r == ST_WAIT && op_r == irq_gen_pkg::CMD_MASK_READ;
	assign link.priority_readback_op = state_r == ST_WAIT && op_r == irq_gen_pkg::CMD_PRIO_READ;
	assign link.ack_strobe = state_r == ST_WAIT && op_r == irq_gen_pkg::CMD_ACK;
	assign link.ack_level = lvl_r;
	assign link.generator_index = idx_r;
	assign link.cfg_mask = mask_r;
	assign link.cfg_priority = prio_r;
	assign o_rdata = rdata_r;
	assign o_irq = |(ists_r & imsk_r);

	always_comb
	begin
		logic [2:0] ev;
		ev = 3'h0;
		state_nxt = state_r;
		op_nxt = op_r;
		idx_nxt = idx_r;
		mask_nxt = mask_r;
		prio_nxt = prio_r;
		lvl_nxt = lvl_r;
		result_nxt = result_r;
		vector_nxt = vector_r;
		imsk_nxt = imsk_r;
		rdata_nxt = 16'h0000;
		unique case (state_r)
			ST_IDLE:
			begin
				if (i_wr && i_addr == irq_gen_pkg::ADDR_CMD)
				begin
					// index only 0 or 1; otherwise refused
					if (i_wdata[15:8] > 8'h01)
						ev[irq_gen_pkg::EV_BAD_INDEX] = 1'b1;
					else
					begin
						op_nxt = i_wdata[2:0];
						idx_nxt = i_wdata[8];
						lvl_nxt = i_wdata[6:4];
						state_nxt = ST_WAIT;
					end
				end
			end
			ST_WAIT:
			begin
				state_nxt = ST_IDLE;
				if (op_r == irq_gen_pkg::CMD_ACK)
					vector_nxt = {2'b00, lvl_r};
				if (op_r != irq_gen_pkg::CMD_MASK_READ && op_r != irq_gen_pkg::CMD_PRIO_READ)
					ev[irq_gen_pkg::EV_DONE] = 1'b1;
			end
			default:
				state_nxt = ST_IDLE;
		endcase
		if (link.readback_valid)
		begin
			result_nxt = link.readback;
			ev[irq_gen_pkg::EV_DONE] = 1'b1;
		end
		// bit 4 tells software which generator answered
		if (link.ack_done)
			vector_nxt = {link.ack_generator, 1'b1, lvl_r};
		if (top_level != 3'h0)
			ev[irq_gen_pkg::EV_REQ] = 1'b1;
		if (i_wr && i_addr == irq_gen_pkg::ADDR_CFG)
		begin
			mask_nxt = i_wdata[7:0];
			prio_nxt = i_wdata[10:8];
		end
		if (i_wr && i_addr == irq_gen_pkg::ADDR_IRQ_MASK)
			imsk_nxt = i_wdata[2:0];
		// set wins over write-one-to-clear
		ists_nxt = ists_r;
		if (i_wr && i_addr == irq_gen_pkg::ADDR_IRQ_STATUS)
			ists_nxt = ists_r & ~i_wdata[2:0];
		ists_nxt = ists_nxt | ev;
		if (i_rd)
		begin
			unique case (i_addr)
				irq_gen_pkg::ADDR_CMD: rdata_nxt = {13'h0000, top_level};
				irq_gen_pkg::ADDR_CFG: rdata_nxt = {5'h00, prio_r, mask_r};
				irq_gen_pkg::ADDR_RESULT: rdata_nxt = {8'h00, result_r};
				irq_gen_pkg::ADDR_IRQ_STATUS: rdata_nxt = {13'h0000, ists_r};
				irq_gen_pkg::ADDR_IRQ_MASK: rdata_nxt = {13'h0000, imsk_r};
				irq_gen_pkg::ADDR_VECTOR: rdata_nxt = {11'h000, vector_r};
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			state_r <= ST_IDLE;
			op_r <= 3'h0;
			idx_r <= 1'b0;
			mask_r <= 8'h00;
			prio_r <= 3'h0;
			lvl_r <= 3'h0;
			result_r <= 8'h00;
			vector_r <= 5'h00;
			ists_r <= 3'h0;
			imsk_r <= 3'h0;
			rdata_r <= 16'h0000;
		end
		else
		begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			idx_r <= idx_nxt;
			mask_r <= mask_nxt;
			prio_r <= prio_nxt;
			lvl_r <= lvl_nxt;
			result_r <= result_nxt;
			vector_r <= vector_nxt;
			ists_r <= ists_nxt;
			imsk_r <= imsk_nxt;
			rdata_r <= rdata_nxt;
		end
	end
endmodule

//--- test/irq_gen_checker.sv
// concurrent checks on the generator link
`timescale 1ns/100ps
module irq_gen_checker (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// link signals
	input wire logic [7:0] irq_n,
	input wire logic configure_op,
	input wire logic mask_readback_op,
	input wire logic priority_readback_op,
	input wire logic [7:0] readback,
	input wire logic readback_valid,
	input wire logic ack_strobe,
	input wire logic [2:0] ack_level,
	input wire logic ack_done
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	two_lines_max_a: assert property ($countones(~irq_n) <= 2)
		else $error("more requests than generators");
	line_zero_idle_a: assert property (irq_n[0])
		else $error("request on line zero");
	ack_level_nonzero_a: assert property (ack_done |-> $past(ack_level) != 3'h0)
		else $error("answer to level zero");
	ack_answers_a: assert property (ack_done |-> $past(ack_strobe))
		else $error("answer without acknowledge");
	// a line may drop only on an answer or a new priority
	request_held_a: assert property (|(irq_n & ~$past(irq_n)) |->
		ack_done || $past(configure_op) || $past(configure_op, 2))
		else $error("request dropped early");
	readback_answer_a: assert property ((mask_readback_op || priority_readback_op) |=>
		readback_valid)
		else $error("readback missing");
	readback_cause_a: assert property (readback_valid |->
		$past(mask_readback_op || priority_readback_op))
		else $error("readback without request");
	readback_hold_a: assert property (!readback_valid |-> $stable(readback))
		else $error("readback changed");
	cover property (ack_done);
	cover property (readback_valid);
	cover property (!irq_n[7]);
endmodule

//--- test/test_dual_vme_interrupt_generator.sv
// self-checking bench for the dual interrupt generator and its handler
`timescale 1ns/100ps
module test_dual_vme_interrupt_generator;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [15:0] i_status = 16'h0000;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [15:0] o_rdata;
	logic o_irq;
	logic [1:0] o_pending;
	logic [15:0] v;
	int num_errors = 0;
	int num_checks = 0;
	irq_gen_if link ();
	always #20 i_mclk = ~i_mclk;
	dual_irq_generator i_dual_irq_generator (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_status(i_status), .link(link.device), .o_pending(o_pending));
	irq_handler i_irq_handler (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
		.link(link.host));
	irq_gen_checker i_irq_gen_checker (.i_mclk(i_mclk), .i_rst(i_rst), .irq_n(link.irq_n),
		.configure_op(link.configure_op), .mask_readback_op(link.mask_readback_op),
		.priority_readback_op(link.priority_readback_op), .readback(link.readback),
		.readback_valid(link.readback_valid), .ack_strobe(link.ack_strobe),
		.ack_level(link.ack_level), .ack_done(link.ack_done));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (num_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one idle cycle after each strobe keeps every signal to one change per step
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		@(posedge i_mclk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
		@(posedge i_mclk);
	endtask
	task automatic cmd(input logic [2:0] op, input logic [2:0] lvl, input logic [7:0] idx);
		wr(irq_gen_pkg::ADDR_CMD, {idx, 1'b0, lvl, 1'b0, op});
		repeat (3) @(posedge i_mclk);
	endtask
	task automatic cfg(input logic [7:0] idx, input logic [2:0] prio, input logic [7:0] m);
		wr(irq_gen_pkg::ADDR_CFG, {5'h00, prio, m});
		cmd(irq_gen_pkg::CMD_CONFIGURE, 3'h0, idx);
	endtask
	task automatic ev(input logic [15:0] bits);
		i_status <= bits;
		@(posedge i_mclk);
		i_status <= 16'h0000;
		repeat (3) @(posedge i_mclk);
	endtask
	task automatic readm(input logic [2:0] op, input logic [7:0] idx);
		cmd(op, 3'h0, idx);
		rd(irq_gen_pkg::ADDR_RESULT, v);
	endtask
	task automatic t_levels();
		for (int l = 1; l < 8; l++)
		begin
			cfg(8'h00, 3'(l), 8'h02);
			ev(16'h0200);
			chk({8'h00, link.irq_n}, {8'h00, 8'hFF ^ (8'h01 << l)});
			cmd(irq_gen_pkg::CMD_ACK, 3'(l), 8'h00);
			chk({8'h00, link.irq_n}, 16'h00FF);
		end
		readm(irq_gen_pkg::CMD_MASK_READ, 8'h00);
		chk(v, 16'h0000);
		ev(16'h0200);
		chk({8'h00, link.irq_n}, 16'h00FF);
		cmd(irq_gen_pkg::CMD_RESTORE, 3'h0, 8'h00);
		readm(irq_gen_pkg::CMD_MASK_READ, 8'h00);
		chk(v, 16'h0002);
		ev(16'h0200);
		chk({8'h00, link.irq_n}, 16'h007F);
		cmd(irq_gen_pkg::CMD_ACK, 3'h7, 8'h00);
	endtask
	task automatic t_both();
		cfg(8'h00, 3'h2, 8'h01);
		cfg(8'h01, 3'h6, 8'h20);
		ev(16'h2100);
		chk({8'h00, link.irq_n}, 16'h00BB);
		chk({14'h0000, o_pending}, 16'h0003);
		rd(irq_gen_pkg::ADDR_CMD, v);
		chk(v, 16'h0006);
		rd(irq_gen_pkg::ADDR_CFG, v);
		chk(v, 16'h0620);
		rd(4'hF, v);
		chk(v, 16'h0000);
		wr(irq_gen_pkg::ADDR_IRQ_MASK, 16'h0001);
		chk({15'h0000, o_irq}, 16'h0001);
		wr(irq_gen_pkg::ADDR_IRQ_MASK, 16'h0000);
		chk({15'h0000, o_irq}, 16'h0000);
		cmd(irq_gen_pkg::CMD_ACK, 3'h2, 8'h00);
		cmd(irq_gen_pkg::CMD_ACK, 3'h6, 8'h00);
		rd(irq_gen_pkg::ADDR_VECTOR, v);
		chk(v, 16'h001E);
		wr(irq_gen_pkg::ADDR_IRQ_STATUS, 16'h0007);
		rd(irq_gen_pkg::ADDR_IRQ_STATUS, v);
		chk(v, 16'h0000);
		wr(irq_gen_pkg::ADDR_IRQ_MASK, 16'h0001);
		chk({15'h0000, o_irq}, 16'h0000);
		readm(irq_gen_pkg::CMD_PRIO_READ, 8'h01);
		chk(v, 16'h0006);
		rd(irq_gen_pkg::ADDR_IRQ_STATUS, v);
		chk(v, 16'h0002);
		readm(irq_gen_pkg::CMD_MASK_READ, 8'h01);
		chk(v, 16'h0000);
	endtask
	task automatic t_bits();
		cfg(8'h00, 3'h5, 8'hFF);
		ev(16'hC0FF);
		chk({8'h00, link.irq_n}, 16'h00FF);
		ev(16'h1000);
		chk({8'h00, link.irq_n}, 16'h00DF);
		cmd(irq_gen_pkg::CMD_ACK, 3'h5, 8'h00);
		cfg(8'h00, 3'h0, 8'h01);
		ev(16'h0100);
		chk({6'h00, o_pending, link.irq_n}, 16'h00FF);
		wr(irq_gen_pkg::ADDR_IRQ_STATUS, 16'h0007);
		cmd(irq_gen_pkg::CMD_CONFIGURE, 3'h0, 8'h02);
		rd(irq_gen_pkg::ADDR_IRQ_STATUS, v);
		chk(v & 16'h0004, 16'h0004);
	endtask
	initial
	begin
		#4000000;
		num_errors++;
		end_sim();
	end
	initial
	begin
		repeat (20) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		chk({8'h00, link.irq_n}, 16'h00FF);
		t_levels();
		t_both();
		t_bits();
		end_sim();
	end
endmodule
